// [hdl/dmsd_pkg.sv]
// Purpose: Shared constants and types of the DRAM mode-setting decoder.
// Assumes: Setting fields are taken from address pins A12..A0 at load time.
// Notes:   Bit positions below are positions within a 13-bit setting register.
package dmsd_pkg;
	localparam int          AW              = 13;
	localparam int          LAT_W           = 5;
	localparam logic [12:0] MR_RESET        = 13'h0000;

	localparam logic [2:0]  BA_BURST_READ   = 3'h0;
	localparam logic [2:0]  BA_DRIVE_LAT    = 3'h1;
	localparam logic [2:0]  BA_WRITE_LAT    = 3'h2;
	localparam logic [2:0]  BA_CAL_READOUT  = 3'h3;

	localparam int          BR_BL_LO        = 0;
	localparam int          BR_BL_HI        = 1;
	localparam int          BR_CL_LO        = 4;
	localparam int          BR_CL_HI        = 6;
	localparam int          BR_PD_EXIT      = 12;
	localparam logic [1:0]  BL_FIXED8       = 2'h0;
	localparam logic [1:0]  BL_ON_FLY       = 2'h1;
	localparam logic [1:0]  BL_FIXED4       = 2'h2;

	localparam int          DL_LOCK_OFF     = 0;
	localparam int          DL_IMP0         = 1;
	localparam int          DL_IMP1         = 5;
	localparam int          DL_TERM0        = 2;
	localparam int          DL_TERM1        = 6;
	localparam int          DL_TERM2        = 9;
	localparam int          DL_AL_LO        = 3;
	localparam int          DL_AL_HI        = 4;
	localparam int          DL_WLEVEL       = 7;
	localparam int          DL_OUT_OFF      = 12;
	localparam logic [1:0]  AL_DISABLED     = 2'h0;
	localparam logic [1:0]  AL_CL_MINUS1    = 2'h1;
	localparam logic [1:0]  AL_CL_MINUS2    = 2'h2;

	localparam int          WL_CWL_LO       = 3;
	localparam int          WL_CWL_HI       = 5;
	localparam int          WL_WTERM_LO     = 9;
	localparam int          WL_WTERM_HI     = 10;

	localparam int          CR_LOC_LO       = 0;
	localparam int          CR_LOC_HI       = 1;
	localparam int          CR_PAT_EN       = 2;
	localparam logic [1:0]  LOC_FIXED_PAT   = 2'h0;

	localparam int          ADDR_AP         = 10;
	localparam int          ADDR_BC         = 12;
	localparam int          ADDR_NIBBLE     = 2;

	localparam logic [4:0]  CL_BASE         = 5'h04;
	localparam logic [4:0]  CWL_BASE        = 5'h05;
	localparam logic [3:0]  BEATS_FULL      = 4'h8;
	localparam logic [3:0]  BEATS_CHOP      = 4'h4;
	localparam logic [7:0]  SLOW_EXIT_CK    = 8'h0A;
	localparam logic [7:0]  FAST_EXIT_CK    = 8'h03;

	typedef enum logic [2:0] {
		CMD_NOP   = 3'b000,
		CMD_LOAD  = 3'b001,
		CMD_REF   = 3'b010,
		CMD_ACT   = 3'b011,
		CMD_READ  = 3'b100,
		CMD_WRITE = 3'b101,
		CMD_PRE   = 3'b110,
		CMD_ZQ    = 3'b111
	} dmsd_cmd_t;

	typedef enum logic [1:0] {
		PWR_ACTIVE  = 2'b00,
		PWR_DOWN    = 2'b01,
		PWR_SELFREF = 2'b10
	} dmsd_pwr_t;
endpackage

// [hdl/dmsd_sync.sv]
// Purpose: Three-stage synchroniser with agreement filter for pin inputs.
// Assumes: Inputs are asynchronous to clk_i.
// Notes:   The output moves only when stages two and three agree.
module dmsd_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} dmsd_sync_st_t;

	dmsd_sync_st_t st_r;
	dmsd_sync_st_t st_nxt;

	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = d_i;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		for (int i = 0; i < W; i++) begin
			if (st_r.s2[i] == st_r.s3[i]) begin
				st_nxt.q[i] = st_r.s3[i];
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q_o = st_r.q;
endmodule

// [hdl/dmsd_delay.sv]
// Purpose: Latency line that releases each started command after N ticks.
// Assumes: lat_i is at least one; overlapping commands are allowed.
// Notes:   A command started with lat_i of N leaves on the Nth later tick.
module dmsd_delay #(
	parameter int DEPTH = 32,
	parameter int PW    = 1
) (
	input  wire logic                     clk_i,
	input  wire logic                     rst_n_i,
	input  wire logic                     tick_i,
	input  wire logic                     start_i,
	input  wire logic [$clog2(DEPTH)-1:0] lat_i,
	input  wire logic [PW-1:0]            pay_i,
	output logic                          done_o,
	output logic      [PW-1:0]            pay_o
);
	typedef struct packed {
		logic [DEPTH-1:0]         busy;
		logic [DEPTH-1:0][PW-1:0] pay;
		logic                     done;
		logic [PW-1:0]            out;
	} dmsd_delay_st_t;

	dmsd_delay_st_t st_r;
	dmsd_delay_st_t st_nxt;

	always_comb begin
		st_nxt      = st_r;
		st_nxt.done = 1'b0;
		if (tick_i) begin
			st_nxt.done = st_r.busy[0];
			st_nxt.out  = st_r.pay[0];
			st_nxt.busy = st_r.busy >> 1;
			st_nxt.pay  = st_r.pay >> PW;
			if (start_i) begin
				st_nxt.busy[lat_i - 1'b1] = 1'b1;
				st_nxt.pay[lat_i - 1'b1]  = pay_i;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign done_o = st_r.done;
	assign pay_o  = st_r.out;
endmodule

// [hdl/dmsd_top.sv]
// Purpose: Mode-setting decode and mode behaviour of a double-data-rate DRAM.
// Assumes: All pins are asynchronous to ref_clk_i; the command clock is sampled.
// Notes:   Commands are taken at the filtered rising edge of the command clock.
//
// Functional notes
// - Exit bit zero freezes lock loop in powerdown.
// - Exit bit one keeps lock loop; fast exit.
// - Load with bank one writes drive settings.
// - Load with bank two writes write-latency settings.
// - Load with bank three writes calibration settings.
// - Lock loop stops in self-refresh, resumes after.
// - Writes need lock loop only with write termination.
// - Driver impedance from drive bits one and five.
// - Write termination applies even with nominal off.
// - Reads and writes held for posted latency.
// - Posted latency: zero, minus one, minus two, reserved.
// - Read latency is posted plus column latency.
// - Write latency is posted plus write column latency.
// - Output-off bit disconnects data and strobe drivers.
// - Write leveling offers only nominal termination.
// - Pattern mode redirects reads to pattern source.
// - Pattern mode allows only reads and loads; reset still works.
// - Autoclose read acts as plain read in pattern mode.
// - Location zero returns alternating zero-one pattern.
module dmsd_top
	import dmsd_pkg::*;
#(
	parameter logic [7:0] SLOW_EXIT = dmsd_pkg::SLOW_EXIT_CK,
	parameter logic [7:0] FAST_EXIT = dmsd_pkg::FAST_EXIT_CK
) (
	input  wire logic                  ref_clk_i,
	input  wire logic                  rst_n_i,
	input  wire logic                  ck_i,
	input  wire logic                  cke_i,
	input  wire logic                  cs_n_i,
	input  wire logic                  ras_n_i,
	input  wire logic                  cas_n_i,
	input  wire logic                  we_n_i,
	input  wire logic [2:0]            ba_i,
	input  wire logic [dmsd_pkg::AW-1:0] addr_i,
	input  wire logic                  term_ctl_i,
	input  wire logic                  dev_reset_n_i,
	output logic      [dmsd_pkg::AW-1:0] burst_read_o,
	output logic      [dmsd_pkg::AW-1:0] drive_lat_o,
	output logic      [dmsd_pkg::AW-1:0] write_lat_o,
	output logic      [dmsd_pkg::AW-1:0] cal_readout_o,
	output logic                       lock_run_o,
	output logic                       exit_wait_o,
	output logic      [1:0]            drive_imp_o,
	output logic      [2:0]            term_value_o,
	output logic                       term_active_o,
	output logic                       write_needs_lock_o,
	output logic      [4:0]            posted_latency_o,
	output logic      [4:0]            read_latency_o,
	output logic      [4:0]            write_latency_o,
	output logic                       array_read_o,
	output logic                       read_autoclose_o,
	output logic                       write_start_o,
	output logic                       cmd_refused_o,
	output logic      [15:0]           dq_o,
	output logic                       dq_oe_o,
	output logic                       dqs_oe_o
);
	import dmsd_pkg::*;

	localparam int PINS = 24;

	typedef struct packed {
		logic [AW-1:0] burst_read;
		logic [AW-1:0] drive_lat;
		logic [AW-1:0] write_lat;
		logic [AW-1:0] cal_readout;
		logic          ck_last;
		logic          cke_prev;
		dmsd_pwr_t     pwr;
		logic [7:0]    exit_cnt;
		logic          exit_wait;
		logic          lock_run;
		logic [1:0]    drive_imp;
		logic [2:0]    term_value;
		logic          term_active;
		logic          wr_lock;
		logic [4:0]    al;
		logic [4:0]    rl;
		logic [4:0]    wl;
		logic          array_read;
		logic          autoclose;
		logic          wr_start;
		logic          refused;
		logic [3:0]    beat;
		logic [3:0]    beats;
		logic [1:0]    loc;
		logic [15:0]   dq;
		logic          dq_oe;
		logic          writing;
	} dmsd_st_t;

	dmsd_st_t            st_r;
	dmsd_st_t            st_nxt;
	logic [1:0]          rst_sync_r;
	logic                rst_n;
	logic [PINS-1:0]     pins_q;
	logic                ck_f;
	logic                cke_f;
	logic                cs_n_f;
	logic                ras_n_f;
	logic                cas_n_f;
	logic                we_n_f;
	logic [2:0]          ba_f;
	logic [AW-1:0]       a_f;
	logic                term_f;
	logic                dreset_n_f;
	logic                ck_rise;
	logic                ck_edge;
	dmsd_cmd_t           cmd;
	logic                cmd_take;
	logic                rd_start;
	logic                wr_go;
	logic [4:0]          rd_pay;
	logic [4:0]          rd_out;
	logic                rd_done;
	logic                wr_done;
	logic [4:0]          cl;
	logic [4:0]          write_column_latency;

	////////////////////////////////////////////////////////////////////////////
	// Reset release and pin synchronisers.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_sync_r <= 2'b00;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	dmsd_sync #(
		.W(PINS)
	) u_pins (
		.clk_i  (ref_clk_i),
		.rst_n_i(rst_n),
		.d_i    ({ck_i, cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, ba_i, addr_i,
		          term_ctl_i, dev_reset_n_i}),
		.q_o    (pins_q)
	);

	assign {ck_f, cke_f, cs_n_f, ras_n_f, cas_n_f, we_n_f, ba_f, a_f, term_f,
	        dreset_n_f} = pins_q;
	assign ck_rise  = ck_f & ~st_r.ck_last;
	assign ck_edge  = ck_f ^ st_r.ck_last;

	////////////////////////////////////////////////////////////////////////////
	// Command decode and latency sums.
	always_comb begin
		if (cs_n_f) begin
			cmd = CMD_NOP;
		end else begin
			case ({ras_n_f, cas_n_f, we_n_f})
				3'b000:  cmd = CMD_LOAD;
				3'b001:  cmd = CMD_REF;
				3'b011:  cmd = CMD_ACT;
				3'b101:  cmd = CMD_READ;
				3'b100:  cmd = CMD_WRITE;
				3'b010:  cmd = CMD_PRE;
				3'b110:  cmd = CMD_ZQ;
				default: cmd = CMD_NOP;
			endcase
		end
	end

	assign cl  = CL_BASE + 5'(st_r.burst_read[BR_CL_HI:BR_CL_LO]);
	assign write_column_latency = CWL_BASE + 5'(st_r.write_lat[WL_CWL_HI:WL_CWL_LO]);

	// Commands count only while the clock enable was and is high.
	assign cmd_take = ck_rise & cke_f & st_r.cke_prev & (st_r.pwr == PWR_ACTIVE);
	assign rd_start = cmd_take & (cmd == CMD_READ) & (st_r.exit_cnt == 8'h00);
	assign wr_go    = cmd_take & (cmd == CMD_WRITE) & ~st_r.cal_readout[CR_PAT_EN]
	                  & (st_r.exit_cnt == 8'h00);

	always_comb begin
		rd_pay[0] = st_r.cal_readout[CR_PAT_EN];
		rd_pay[1] = a_f[ADDR_AP] & ~st_r.cal_readout[CR_PAT_EN];
		rd_pay[2] = (st_r.burst_read[BR_BL_HI:BR_BL_LO] == BL_FIXED4)
		            | ((st_r.burst_read[BR_BL_HI:BR_BL_LO] == BL_ON_FLY) & ~a_f[ADDR_BC]);
		rd_pay[4:3] = st_r.cal_readout[CR_LOC_HI:CR_LOC_LO];
	end

	dmsd_delay #(
		.DEPTH(32),
		.PW   (5)
	) u_rd_lat (
		.clk_i  (ref_clk_i),
		.rst_n_i(rst_n),
		.tick_i (ck_rise),
		.start_i(rd_start),
		.lat_i  (st_r.rl),
		.pay_i  (rd_pay),
		.done_o (rd_done),
		.pay_o  (rd_out)
	);

	dmsd_delay #(
		.DEPTH(32),
		.PW   (1)
	) u_wr_lat (
		.clk_i  (ref_clk_i),
		.rst_n_i(rst_n),
		.tick_i (ck_rise),
		.start_i(wr_go),
		.lat_i  (st_r.wl),
		.pay_i  (1'b0),
		.done_o (wr_done),
		.pay_o  ()
	);

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic.
	always_comb begin
		st_nxt            = st_r;
		st_nxt.ck_last    = ck_f;
		st_nxt.array_read = 1'b0;
		st_nxt.autoclose  = 1'b0;
		st_nxt.wr_start   = 1'b0;
		st_nxt.refused    = 1'b0;

		if (ck_rise) begin
			st_nxt.cke_prev = cke_f;
			if (st_r.exit_cnt != 8'h00) begin
				st_nxt.exit_cnt = st_r.exit_cnt - 8'h01;
			end
		end

		// Power state follows clock enable transitions.
		if (ck_rise) begin
			case (st_r.pwr)
				PWR_ACTIVE: begin
					if (st_r.cke_prev & ~cke_f) begin
						if (st_r.cal_readout[CR_PAT_EN]) begin
							st_nxt.refused = 1'b1;
						end else if (!cs_n_f && cmd == CMD_REF) begin
							st_nxt.pwr = PWR_SELFREF;
						end else begin
							st_nxt.pwr = PWR_DOWN;
						end
					end
				end
				PWR_DOWN: begin
					if (cke_f) begin
						st_nxt.pwr      = PWR_ACTIVE;
						st_nxt.cke_prev = 1'b0;
						if (st_r.burst_read[BR_PD_EXIT]) begin
							st_nxt.exit_cnt = FAST_EXIT;
						end else begin
							st_nxt.exit_cnt = SLOW_EXIT;
						end
					end
				end
				PWR_SELFREF: begin
					if (cke_f) begin
						st_nxt.pwr      = PWR_ACTIVE;
						st_nxt.cke_prev = 1'b0;
					end
				end
				default: st_nxt.pwr = PWR_ACTIVE;
			endcase
		end

		// Setting loads; in pattern mode only reads and loads are taken.
		if (cmd_take) begin
			if (st_r.cal_readout[CR_PAT_EN] && cmd != CMD_READ && cmd != CMD_LOAD
			    && cmd != CMD_NOP) begin
				st_nxt.refused = 1'b1;
			end else if (cmd == CMD_LOAD) begin
				case (ba_f)
					BA_BURST_READ:  st_nxt.burst_read  = a_f;
					BA_DRIVE_LAT:   st_nxt.drive_lat   = a_f;
					BA_WRITE_LAT:   st_nxt.write_lat   = a_f;
					BA_CAL_READOUT: st_nxt.cal_readout = a_f;
					default:        st_nxt.refused     = 1'b0;
				endcase
			end
		end

		// Lock loop runs unless disabled, in self-refresh or in a slow-exit powerdown.
		st_nxt.lock_run = ~st_r.drive_lat[DL_LOCK_OFF] & (st_r.pwr != PWR_SELFREF)
		                  & ~((st_r.pwr == PWR_DOWN) & ~st_r.burst_read[BR_PD_EXIT]);

		st_nxt.drive_imp  = {st_r.drive_lat[DL_IMP1], st_r.drive_lat[DL_IMP0]};

		case (st_r.drive_lat[DL_AL_HI:DL_AL_LO])
			AL_DISABLED:  st_nxt.al = 5'h00;
			AL_CL_MINUS1: st_nxt.al = cl - 5'h01;
			AL_CL_MINUS2: st_nxt.al = cl - 5'h02;
			default:      st_nxt.al = 5'h00;
		endcase
		st_nxt.rl = st_r.al + cl;
		st_nxt.wl = st_r.al + write_column_latency;

		// Write termination is dropped during write leveling.
		st_nxt.wr_lock = (st_r.write_lat[WL_WTERM_HI:WL_WTERM_LO] != 2'h0)
		                 & ~st_r.drive_lat[DL_WLEVEL];
		if (wr_go) begin
			st_nxt.writing = 1'b1;
		end else if (wr_done) begin
			st_nxt.writing  = 1'b0;
			st_nxt.wr_start = 1'b1;
		end
		if (st_r.writing && st_r.wr_lock) begin
			st_nxt.term_value = {1'b0, st_r.write_lat[WL_WTERM_HI:WL_WTERM_LO]};
		end else begin
			st_nxt.term_value = {st_r.drive_lat[DL_TERM2], st_r.drive_lat[DL_TERM1],
			                     st_r.drive_lat[DL_TERM0]};
		end
		st_nxt.term_active = term_f & (st_nxt.term_value != 3'h0);

		// Read completion: array or pattern burst.
		if (rd_done) begin
			if (rd_out[0]) begin
				st_nxt.beat  = 4'h0;
				st_nxt.beats = rd_out[2] ? BEATS_CHOP : BEATS_FULL;
				st_nxt.loc   = rd_out[4:3];
				st_nxt.dq_oe = ~st_r.drive_lat[DL_OUT_OFF];
			end else begin
				st_nxt.array_read = 1'b1;
				st_nxt.autoclose  = rd_out[1];
			end
		end else if (st_r.beats != 4'h0 && ck_edge) begin
			st_nxt.dq = {16{(st_r.loc == LOC_FIXED_PAT) & st_r.beat[0]}};
			st_nxt.beat = st_r.beat + 4'h1;
			if (st_r.beat == st_r.beats) begin
				st_nxt.beats = 4'h0;
				st_nxt.dq_oe = 1'b0;
				st_nxt.dq    = 16'h0000;
			end
		end
		if (st_r.drive_lat[DL_OUT_OFF]) begin
			st_nxt.dq_oe = 1'b0;
		end

		// Device reset pin clears all settings, in pattern mode too.
		if (!dreset_n_f) begin
			st_nxt.burst_read  = MR_RESET;
			st_nxt.drive_lat   = MR_RESET;
			st_nxt.write_lat   = MR_RESET;
			st_nxt.cal_readout = MR_RESET;
			st_nxt.pwr         = PWR_ACTIVE;
			st_nxt.exit_cnt    = 8'h00;
			st_nxt.beats       = 4'h0;
			st_nxt.dq_oe       = 1'b0;
			st_nxt.writing     = 1'b0;
		end
		st_nxt.exit_wait = (st_nxt.exit_cnt != 8'h00);
	end

	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs, all taken from the state register.
	assign burst_read_o       = st_r.burst_read;
	assign drive_lat_o        = st_r.drive_lat;
	assign write_lat_o        = st_r.write_lat;
	assign cal_readout_o      = st_r.cal_readout;
	assign lock_run_o         = st_r.lock_run;
	assign exit_wait_o        = st_r.exit_wait;
	assign drive_imp_o        = st_r.drive_imp;
	assign term_value_o       = st_r.term_value;
	assign term_active_o      = st_r.term_active;
	assign write_needs_lock_o = st_r.wr_lock;
	assign posted_latency_o   = st_r.al;
	assign read_latency_o     = st_r.rl;
	assign write_latency_o    = st_r.wl;
	assign array_read_o       = st_r.array_read;
	assign read_autoclose_o   = st_r.autoclose;
	assign write_start_o      = st_r.wr_start;
	assign cmd_refused_o      = st_r.refused;
	assign dq_o               = st_r.dq;
	assign dq_oe_o            = st_r.dq_oe;
	assign dqs_oe_o           = st_r.dq_oe;
endmodule

// [test/dmsd_chk.sv]
// Purpose: Port assertions for the mode-setting decoder.
// Assumes: Derived outputs settle within eight system cycles.
// Notes:   Bound into every instance of the top module.
module dmsd_chk (
	input wire logic        ref_clk_i,
	input wire logic        rst_n_i,
	input wire logic        cs_n_i,
	input wire logic        dev_reset_n_i,
	input wire logic [12:0] burst_read_o,
	input wire logic [12:0] drive_lat_o,
	input wire logic [12:0] write_lat_o,
	input wire logic [12:0] cal_readout_o,
	input wire logic [1:0]  drive_imp_o,
	input wire logic        write_needs_lock_o,
	input wire logic [4:0]  posted_latency_o,
	input wire logic [4:0]  read_latency_o,
	input wire logic [4:0]  write_latency_o,
	input wire logic        array_read_o,
	input wire logic        read_autoclose_o,
	input wire logic        write_start_o,
	input wire logic [15:0] dq_o,
	input wire logic        dq_oe_o,
	input wire logic        dqs_oe_o
);
	logic [4:0] cl;
	logic [4:0] al;
	logic [4:0] write_column_latency;
	logic [4:0] quiet_r;
	logic [4:0] quiet_nxt;
	always_comb begin
		cl = {2'h0, burst_read_o[6:4]} + 5'h04;
		write_column_latency = {2'h0, write_lat_o[5:3]} + 5'h05;
		al = 5'h00;
		if (drive_lat_o[4:3] == 2'h1) al = cl - 5'h01;
		if (drive_lat_o[4:3] == 2'h2) al = cl - 5'h02;
		quiet_nxt = quiet_r + {4'h0, quiet_r != 5'h1F};
		if (!cs_n_i || !dev_reset_n_i) quiet_nxt = 5'h00;
	end
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) quiet_r <= 5'h00;
		else quiet_r <= quiet_nxt;
	end
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_settled;
		($stable(burst_read_o) && $stable(drive_lat_o) && $stable(write_lat_o))[*8];
	endsequence
	property p_imp; s_settled |-> drive_imp_o == {drive_lat_o[5], drive_lat_o[1]}; endproperty
	a_imp: assert property (p_imp) else $error("impedance code wrong");
	property p_al; s_settled |-> posted_latency_o == al; endproperty
	a_al: assert property (p_al) else $error("posted latency wrong");
	property p_rl; s_settled |-> read_latency_o == al + cl; endproperty
	a_rl: assert property (p_rl) else $error("read latency wrong");
	property p_wl; s_settled |-> write_latency_o == al + write_column_latency; endproperty
	a_wl: assert property (p_wl) else $error("write latency wrong");
	property p_wlock;
		s_settled |-> write_needs_lock_o == ((|write_lat_o[10:9]) && !drive_lat_o[7]);
	endproperty
	a_wlock: assert property (p_wlock) else $error("write lock need wrong");
	property p_off; drive_lat_o[12] && $past(drive_lat_o[12]) |-> !dq_oe_o && !dqs_oe_o; endproperty
	a_off: assert property (p_off) else $error("outputs driven while off");
	property p_lane; dq_oe_o |-> dq_o == 16'h0000 || dq_o == 16'hFFFF; endproperty
	a_lane: assert property (p_lane) else $error("data lanes differ");
	property p_loc; dq_oe_o && cal_readout_o[2] && cal_readout_o[1:0] != 2'h0 |-> dq_o == 16'h0000; endproperty
	a_loc: assert property (p_loc) else $error("spare location not zero");
	property p_rda; read_autoclose_o |-> array_read_o && !cal_readout_o[2]; endproperty
	a_rda: assert property (p_rda) else $error("autoclose in pattern mode");
	property p_nowr; cal_readout_o[2] |-> !write_start_o; endproperty
	a_nowr: assert property (p_nowr) else $error("write in pattern mode");
	property p_hold;
		quiet_r > 5'h0C |-> $stable({burst_read_o, drive_lat_o, write_lat_o, cal_readout_o});
	endproperty
	a_hold: assert property (p_hold) else $error("setting changed without load");
endmodule
bind dmsd_top dmsd_chk u_chk (.ref_clk_i, .rst_n_i, .cs_n_i, .dev_reset_n_i, .burst_read_o,
	.drive_lat_o, .write_lat_o, .cal_readout_o, .drive_imp_o, .write_needs_lock_o,
	.posted_latency_o, .read_latency_o, .write_latency_o, .array_read_o, .read_autoclose_o,
	.write_start_o, .dq_o, .dq_oe_o, .dqs_oe_o);

// [test/dmsd_ctl_model.sv]
// Purpose: Memory controller model issuing commands on the command clock.
// Assumes: Command clock is one eighth of the system clock, free running.
// Notes:   Pins change at a clock fall and hold through the next rise.
module dmsd_ctl_model (
	input  wire logic        ref_clk_i,
	output logic             ck_o,
	output logic             cke_o,
	output logic             cs_n_o,
	output logic             ras_n_o,
	output logic             cas_n_o,
	output logic             we_n_o,
	output logic [2:0]       ba_o,
	output logic [12:0]      addr_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int      ph = 0;
	int      rises = 0;
	initial begin
		ck_o = 1'b0;
		cke_o = 1'b1;
		{cs_n_o, ras_n_o, cas_n_o, we_n_o, ba_o, addr_o} = {4'hF, 16'h0000};
	end
	always @(negedge ref_clk_i) begin
		ph <= (ph + 1) % 4;
		if (ph == 3) ck_o <= ~ck_o;
	end
	always @(posedge ck_o) rises++;
	// Released address shows its inverse so a late sample cannot match by chance.
	task automatic send(input logic [3:0] c, input logic [2:0] b, input logic [12:0] a,
			input logic k);
		@(negedge ck_o);
		{cs_n_o, ras_n_o, cas_n_o, we_n_o} = c;
		ba_o = b;
		addr_o = a;
		cke_o = k;
		@(negedge ck_o);
		{cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hF;
		ba_o = ~b;
		addr_o = ~a;
	endtask
endmodule

// [test/dmsd_top_tb.sv]
// Purpose: Self-checking bench for the mode-setting decoder.
// Assumes: Controller model drives all command pins.
// Notes:   Exit delays shortened to two and one command cycles.
module dmsd_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [3:0] LD = 4'h0;
	localparam logic [3:0] RF = 4'h1;
	localparam logic [3:0] PR = 4'h2;
	localparam logic [3:0] AC = 4'h3;
	localparam logic [3:0] WR = 4'h4;
	localparam logic [3:0] RD = 4'h5;
	localparam logic [3:0] NP = 4'hF;
	logic        ref_clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        dev_reset_n_i = 1'b1;
	logic        term_ctl_i = 1'b0;
	logic        ck_i, cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i;
	logic [2:0]  ba_i, term_value_o;
	logic [12:0] addr_i, burst_read_o, drive_lat_o, write_lat_o, cal_readout_o;
	logic        lock_run_o, exit_wait_o, term_active_o, write_needs_lock_o;
	logic        array_read_o, read_autoclose_o, write_start_o, cmd_refused_o;
	logic        dq_oe_o, dqs_oe_o;
	logic [1:0]  drive_imp_o;
	logic [4:0]  posted_latency_o, read_latency_o, write_latency_o;
	logic [15:0] dq_o;
	logic [12:0] pcal [3] = '{13'h0004, 13'h0004, 13'h0005};
	logic [12:0] pad [3] = '{13'h1000, 13'h0400, 13'h1000};
	int          pex [3] = '{4, 2, 0};
	int          err_total = 0;
	int          checks_done = 0;
	int          cyc = 0;
	int          n, r0;
	dmsd_ctl_model ctl (.ref_clk_i, .ck_o(ck_i), .cke_o(cke_i), .cs_n_o(cs_n_i),
		.ras_n_o(ras_n_i), .cas_n_o(cas_n_i), .we_n_o(we_n_i), .ba_o(ba_i), .addr_o(addr_i));
	dmsd_top #(.SLOW_EXIT(8'h02), .FAST_EXIT(8'h01)) uut (.ref_clk_i, .rst_n_i, .ck_i,
		.cke_i, .cs_n_i, .ras_n_i, .cas_n_i, .we_n_i, .ba_i, .addr_i, .term_ctl_i,
		.dev_reset_n_i, .burst_read_o, .drive_lat_o, .write_lat_o, .cal_readout_o,
		.lock_run_o, .exit_wait_o, .drive_imp_o, .term_value_o, .term_active_o,
		.write_needs_lock_o, .posted_latency_o, .read_latency_o, .write_latency_o,
		.array_read_o, .read_autoclose_o, .write_start_o, .cmd_refused_o, .dq_o,
		.dq_oe_o, .dqs_oe_o);
	task automatic complete_run();
		if (err_total == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic ok, input string s);
		checks_done++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("CHECK FAILED %0t %s", $time, s);
		end
	endtask
	function automatic logic pk(input int s);
		return s == 0 ? array_read_o : s == 1 ? write_start_o : s == 2 ? cmd_refused_o : dq_oe_o;
	endfunction
	task automatic waitp(input int s, output int k);
		k = 0;
		while (pk(s) !== 1'b1 && k < 400) begin
			@(negedge ref_clk_i);
			k++;
		end
	endtask
	task automatic ld(input logic [2:0] b, input logic [12:0] a);
		ctl.send(LD, b, a, 1'b1);
		repeat (10) @(negedge ref_clk_i);
	endtask
	// Counts rising beats of the pattern while the outputs drive.
	task automatic burst(input logic [12:0] a, input int e);
		int  k;
		int  ups;
		logic last;
		ctl.send(RD, 3'h0, a, 1'b1);
		waitp(3, k);
		chk(k < 400 && dq_o === 16'h0000, "pattern start");
		ups = 0;
		last = 1'b0;
		while (dq_oe_o === 1'b1 && k < 400) begin
			@(negedge ref_clk_i);
			k++;
			if (dq_o[0] === 1'b1 && last === 1'b0) ups++;
			last = dq_o[0];
		end
		chk(ups === e, "pattern beats");
	endtask
	task automatic pd(input logic [3:0] c, input logic [12:0] a, input logic e);
		ld(3'h0, a);
		ctl.send(c, 3'h0, 13'h0000, 1'b0);
		repeat (40) @(negedge ref_clk_i);
		chk(lock_run_o === e, "lock loop in low power");
		ctl.send(NP, 3'h0, 13'h0000, 1'b1);
		repeat (60) @(negedge ref_clk_i);
		chk(lock_run_o === 1'b1, "lock loop after exit");
	endtask
	initial begin
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 40000) begin
			err_total++;
			complete_run();
		end
	end
	initial begin
		repeat (16) @(negedge ref_clk_i);
		rst_n_i = 1'b1;
		repeat (20) @(negedge ref_clk_i);
		ld(3'h0, 13'h0021);
		ld(3'h1, 13'h0262);
		ld(3'h2, 13'h0638);
		ld(3'h3, 13'h0003);
		ld(3'h4, 13'h1FFF);
		chk({burst_read_o, drive_lat_o, write_lat_o, cal_readout_o} ===
			{13'h0021, 13'h0262, 13'h0638, 13'h0003}, "setting load");
		for (int j = 0; j < 4; j++) begin
			r0 = (j + 2) % 4;
			ld(3'h1, 13'h0262 | 13'(r0 << 3));
			n = (r0 == 1) ? 5 : (r0 == 2) ? 4 : 0;
			chk(posted_latency_o === 5'(n) && read_latency_o === 5'(n + 6), "latency");
		end
		for (int j = 0; j < 2; j++) begin
			ctl.send(AC, 3'h0, 13'h0000, 1'b1);
			ctl.send(RD, 3'h0, 13'(j * 1024), 1'b1);
			r0 = ctl.rises;
			waitp(0, n);
			chk(ctl.rises - r0 === 11 && read_autoclose_o === 1'(j), "read delay");
		end
		ctl.send(WR, 3'h0, 13'h0000, 1'b1);
		r0 = ctl.rises;
		waitp(1, n);
		chk(ctl.rises - r0 === 17, "write delay");
		ctl.send(PR, 3'h0, 13'h0400, 1'b1);
		for (int j = 0; j < 3; j++) begin
			ld(3'h3, pcal[j]);
			burst(pad[j], pex[j]);
		end
		fork
			ctl.send(WR, 3'h0, 13'h0000, 1'b1);
			waitp(2, n);
		join
		chk(n < 400, "write not refused");
		dev_reset_n_i = 1'b0;
		repeat (10) @(negedge ref_clk_i);
		dev_reset_n_i = 1'b1;
		repeat (10) @(negedge ref_clk_i);
		chk({burst_read_o, drive_lat_o, write_lat_o, cal_readout_o} === 52'h0, "reset");
		ld(3'h1, 13'h1000);
		ld(3'h3, 13'h0004);
		ctl.send(RD, 3'h0, 13'h1000, 1'b1);
		waitp(3, n);
		chk(n === 400, "outputs not off");
		ld(3'h3, 13'h0000);
		pd(NP, 13'h0021, 1'b0);
		pd(NP, 13'h1021, 1'b1);
		pd(RF, 13'h1021, 1'b0);
		ld(3'h1, 13'h0001);
		chk(lock_run_o === 1'b0 && term_value_o === 3'h0 && term_active_o === 1'b0
			&& exit_wait_o === 1'b0, "lock off");
		complete_run();
	end
endmodule
